/* File: hw/serial_shift_pkg.sv */
// Constants and types for the clocked serial shift interface.
// Assumes a 40 MHz core clock and an APB register bus with 32-bit data.
package serial_shift_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_PORT_MODE_A   = 8'h04;
  localparam logic [7:0] IDX_SERIAL_MODE   = 8'h05;
  localparam logic [7:0] IDX_SHIFT_LOW     = 8'h06;
  localparam logic [7:0] IDX_SHIFT_HIGH    = 8'h07;
  localparam logic [7:0] IDX_PORT_MODE_C   = 8'h25;
  localparam logic [7:0] IDX_COMMAND       = 8'h30;
  localparam logic [7:0] IDX_STATUS        = 8'h31;

  // Field positions
  localparam int COMMAND_START_BIT = 0;
  localparam int STATUS_SCK_BIT    = 0;
  localparam int STATUS_SO_BIT     = 1;
  localparam int STATUS_DONE_BIT   = 2;
  localparam int STATUS_STATE_LSB  = 4;
  localparam int STATUS_COUNT_LSB  = 8;
  localparam int PMC_DIV_RANGE_BIT = 0;
  localparam int PMC_IDLE_BIT      = 1;

  // Values after reset, and the last count value
  localparam logic [3:0] SERIAL_MODE_RESET = 4'h0;
  localparam logic [2:0] PORT_MODE_A_RESET = 3'h0;
  localparam logic [2:0] COUNT_RESET       = 3'h0;
  localparam logic [2:0] COUNT_LAST        = 3'h7;
  localparam logic       SO_RESET          = 1'b1;
  localparam logic       IDLE_RESET        = 1'b1;

  // Cycle counts, top rate code and divider counter width
  localparam int MODE_SETTLE_CYCLES = 2;
  localparam int DIV_BASE_LOW       = 2;
  localparam int DIV_BASE_HIGH      = 4;
  localparam int DIV_TOP_CODE       = 5;
  localparam int DIV_CNT_W          = 13;

  // Transfer modes held in the two low bits of port_mode_a
  typedef enum logic [1:0] {
    MODE_CONT_CLOCK = 2'b00,
    MODE_TRANSMIT   = 2'b01,
    MODE_RECEIVE    = 2'b10,
    MODE_TX_RX      = 2'b11
  } xfer_mode_t;

  typedef enum logic [1:0] {
    ST_START_WAIT = 2'b00,
    ST_CLOCK_WAIT = 2'b01,
    ST_TRANSFER   = 2'b10,
    ST_CONT_CLOCK = 2'b11
  } ser_state_t;

  // serial_mode_reg layout; rate codes 110 and 111 pick the external clock
  typedef struct packed {
    logic       clk_pin_en;
    logic [2:0] clock_rate_field;
  } serial_mode_t;

  localparam logic [1:0] RATE_EXTERNAL_TOP = 2'b11;

endpackage

/* File: hw/serial_shift_if.sv */
// Clocked serial shift interface: APB slave, clock generator, state machine.
// Assumes SCK and SI arrive asynchronously; SCK is open to a peer when external.
//
// The APB slave port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module serial_shift_if (
  input  wire logic        clock,     // 40 MHz core clock
  input  wire logic        arst_n,    // Asynchronous reset, active low
  input  wire logic        psel,      // APB select
  input  wire logic        penable,   // APB enable
  input  wire logic        pwrite,    // APB direction
  input  wire logic [7:0]  paddr,     // APB byte address
  input  wire logic [31:0] pwdata,    // APB write data
  output logic      [31:0] prdata,    // APB read data
  output logic             pready,    // APB ready
  output logic             pslverr,   // APB error, unmapped address
  input  wire logic        sck_in,    // Serial clock pin level
  output logic             sck_out,   // Serial clock drive value
  output logic             sck_oe_n,  // Serial clock drive enable, low drives
  input  wire logic        si_in,     // Serial input pin
  output logic             so_out     // Serial output pin
);

  // Reset release is synchronised; assertion stays asynchronous
  logic rst_a_q;
  logic rst_n_q;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_a_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_a_q <= 1'b1;
      rst_n_q <= rst_a_q;
    end
  end

  // APB decode; no wait state, ready and read data are registered in the setup cycle so all answers come from flip-flops
  logic [7:0] idx;
  logic       setup;
  logic       access;
  logic       wr;
  logic       mapped;
  assign idx    = {2'b00, paddr[7:2]};
  assign setup  = psel & ~penable;
  assign access = psel & penable & pready;
  assign wr     = access & pwrite;
  always_comb begin
    case (idx)
      serial_shift_pkg::IDX_PORT_MODE_A, serial_shift_pkg::IDX_SERIAL_MODE,
      serial_shift_pkg::IDX_SHIFT_LOW, serial_shift_pkg::IDX_SHIFT_HIGH,
      serial_shift_pkg::IDX_PORT_MODE_C, serial_shift_pkg::IDX_COMMAND,
      serial_shift_pkg::IDX_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  logic wr_pma;
  logic wr_smr;
  logic wr_srl;
  logic wr_sru;
  logic wr_pmc;
  logic wr_cmd;
  logic wr_stat;
  logic start_op;
  assign wr_pma   = wr & (idx == serial_shift_pkg::IDX_PORT_MODE_A);
  assign wr_smr   = wr & (idx == serial_shift_pkg::IDX_SERIAL_MODE);
  assign wr_srl   = wr & (idx == serial_shift_pkg::IDX_SHIFT_LOW);
  assign wr_sru   = wr & (idx == serial_shift_pkg::IDX_SHIFT_HIGH);
  assign wr_pmc   = wr & (idx == serial_shift_pkg::IDX_PORT_MODE_C);
  assign wr_cmd   = wr & (idx == serial_shift_pkg::IDX_COMMAND);
  assign wr_stat  = wr & (idx == serial_shift_pkg::IDX_STATUS);
  assign start_op = wr_cmd & pwdata[serial_shift_pkg::COMMAND_START_BIT];

  // Registers
  serial_shift_pkg::serial_mode_t smr_q, smr_d1_q, smr_eff_q;
  serial_shift_pkg::ser_state_t   state_q;
  logic [2:0] pma_q;
  logic       div_range_q;
  logic       idle_q;
  logic       done_q;
  logic       so_q;
  logic       first_low_q;
  logic [7:0] shift_q;
  logic [2:0] count_q;

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      smr_q     <= serial_shift_pkg::SERIAL_MODE_RESET;
      smr_d1_q  <= serial_shift_pkg::SERIAL_MODE_RESET;
      smr_eff_q <= serial_shift_pkg::SERIAL_MODE_RESET;
    end else begin
      if (wr_smr)
        smr_q <= pwdata[3:0];
      // New mode settles after two cycles
      smr_d1_q  <= smr_q;
      smr_eff_q <= smr_d1_q;
    end
  end

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q)
      pma_q <= serial_shift_pkg::PORT_MODE_A_RESET;
    else if (wr_pma)
      pma_q <= pwdata[2:0];
  end

  logic in_xfer;
  assign in_xfer = (state_q == serial_shift_pkg::ST_TRANSFER);

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      div_range_q <= 1'b0;
      idle_q      <= serial_shift_pkg::IDLE_RESET;
    end else if (wr_pmc && !in_xfer) begin
      div_range_q <= pwdata[serial_shift_pkg::PMC_DIV_RANGE_BIT];
      idle_q      <= pwdata[serial_shift_pkg::PMC_IDLE_BIT];
    end
  end

  // Clock decode from the settled mode register; transfer mode straight from pma_q
  logic ext_clk;
  logic pin_en;
  logic cont_mode;
  logic tx_en;
  logic rx_en;
  serial_shift_pkg::xfer_mode_t mode;
  assign mode      = serial_shift_pkg::xfer_mode_t'(pma_q[1:0]);
  assign pin_en    = smr_eff_q.clk_pin_en;
  assign ext_clk   = (smr_eff_q.clock_rate_field[2:1] == serial_shift_pkg::RATE_EXTERNAL_TOP);
  assign cont_mode = (mode == serial_shift_pkg::MODE_CONT_CLOCK);
  assign tx_en     = (mode == serial_shift_pkg::MODE_TRANSMIT) ||
                     (mode == serial_shift_pkg::MODE_TX_RX);
  assign rx_en     = (mode == serial_shift_pkg::MODE_RECEIVE) ||
                     (mode == serial_shift_pkg::MODE_TX_RX);

  // Half period in cycles equals the prescaler ratio
  logic [serial_shift_pkg::DIV_CNT_W-1:0] half_period, div_q;
  logic [3:0] shamt;
  always_comb begin
    shamt = {1'b0, (3'(serial_shift_pkg::DIV_TOP_CODE) - smr_eff_q.clock_rate_field)} << 1;
    half_period = (div_range_q ? serial_shift_pkg::DIV_CNT_W'(serial_shift_pkg::DIV_BASE_HIGH)
                               : serial_shift_pkg::DIV_CNT_W'(serial_shift_pkg::DIV_BASE_LOW))
                  << shamt;
  end

  // Internal clock idles high and runs in every state except start wait
  // Divider restarts whenever the clock is held, so the first half is full
  logic int_run;
  logic sck_q;
  logic int_fall;
  logic int_rise;
  logic div_end;
  assign int_run  = pin_en & ~ext_clk & ~wr_smr &
                    (state_q != serial_shift_pkg::ST_START_WAIT);
  assign div_end  = (div_q == half_period - 1'b1);
  assign int_fall = int_run & div_end & sck_q;
  assign int_rise = int_run & div_end & ~sck_q;

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      div_q <= '0;
      sck_q <= 1'b1;
    end else if (!int_run) begin
      div_q <= '0;
      sck_q <= 1'b1;
    end else if (div_end) begin
      div_q <= '0;
      sck_q <= ~sck_q;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // External clock and data input synchronisers
  // Third stage filters a one-cycle glitch on the pin
  logic sck_s1_q, sck_s2_q, sck_s3_q, sck_lvl_q;
  logic si_s1_q, si_s2_q, si_s3_q, si_lvl_q;
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      {sck_s1_q, sck_s2_q, sck_s3_q, sck_lvl_q} <= 4'hF;
      {si_s1_q, si_s2_q, si_s3_q, si_lvl_q}     <= 4'h0;
    end else begin
      sck_s1_q <= sck_in;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
      si_s1_q  <= si_in;
      si_s2_q  <= si_s1_q;
      si_s3_q  <= si_s2_q;
      if (sck_s2_q == sck_s3_q)
        sck_lvl_q <= sck_s3_q;
      if (si_s2_q == si_s3_q)
        si_lvl_q <= si_s3_q;
    end
  end

  logic ext_fall;
  logic ext_rise;
  logic ev_fall;
  logic ev_rise;
  assign ext_fall = (sck_s2_q == sck_s3_q) & sck_lvl_q & ~sck_s3_q;
  assign ext_rise = (sck_s2_q == sck_s3_q) & ~sck_lvl_q & sck_s3_q;
  // A mode write keeps the clock off the counter and data register
  assign ev_fall  = pin_en & ~wr_smr & (ext_clk ? ext_fall : int_fall);
  assign ev_rise  = pin_en & ~wr_smr & (ext_clk ? ext_rise : int_rise);

  logic last_rise;
  logic leave_abort;
  assign last_rise   = in_xfer & ev_rise & (count_q == serial_shift_pkg::COUNT_LAST);
  assign leave_abort = in_xfer & (wr_smr | start_op);

  // Control state machine
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= serial_shift_pkg::ST_START_WAIT;
    end else if (wr_smr) begin
      state_q <= serial_shift_pkg::ST_START_WAIT;
    end else begin
      case (state_q)
        serial_shift_pkg::ST_START_WAIT: begin
          if (start_op)
            state_q <= serial_shift_pkg::ST_CLOCK_WAIT;
        end
        serial_shift_pkg::ST_CLOCK_WAIT: begin
          if (ev_fall)
            state_q <= (!ext_clk && cont_mode) ? serial_shift_pkg::ST_CONT_CLOCK
                                               : serial_shift_pkg::ST_TRANSFER;
        end
        serial_shift_pkg::ST_TRANSFER: begin
          if (start_op)
            state_q <= serial_shift_pkg::ST_CLOCK_WAIT;
          else if (last_rise)
            state_q <= ext_clk ? serial_shift_pkg::ST_CLOCK_WAIT
                               : serial_shift_pkg::ST_START_WAIT;
        end
        serial_shift_pkg::ST_CONT_CLOCK: state_q <= serial_shift_pkg::ST_CONT_CLOCK;
        default: state_q <= serial_shift_pkg::ST_START_WAIT;
      endcase
    end
  end

  // Counter counts rises; any exit from transfer or start clears it
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q)
      count_q <= serial_shift_pkg::COUNT_RESET;
    else if (wr_smr || start_op || last_rise)
      count_q <= serial_shift_pkg::COUNT_RESET;
    else if (in_xfer && ev_rise)
      count_q <= count_q + 1'b1;
  end

  // Set while the first low half of a transfer is in progress
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q)
      first_low_q <= 1'b0;
    else if (state_q == serial_shift_pkg::ST_CLOCK_WAIT && ev_fall && !wr_smr)
      first_low_q <= 1'b1;
    else if (ev_rise || !in_xfer || start_op)
      first_low_q <= 1'b0;
  end

  // Done flag; a set in the clearing cycle wins
  logic done_set;
  assign done_set = last_rise | (leave_abort & ~first_low_q);
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q)
      done_q <= 1'b0;
    else if (done_set)
      done_q <= 1'b1;
    else if (wr_stat && pwdata[serial_shift_pkg::STATUS_DONE_BIT])
      done_q <= 1'b0;
  end

  // Data register: LSB out first, receive bit enters at the top
  logic shifting;
  assign shifting = (state_q == serial_shift_pkg::ST_CLOCK_WAIT || in_xfer) && ev_rise;
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      shift_q <= 8'h00;
    end else if (shifting) begin
      shift_q <= {(rx_en ? si_lvl_q : shift_q[0]), shift_q[7:1]};
    end else begin
      if (wr_srl)
        shift_q[3:0] <= pwdata[3:0];
      if (wr_sru)
        shift_q[7:4] <= pwdata[3:0];
    end
  end

  // SO holds a defined level from reset rather than floating
  logic out_fall;
  assign out_fall = ev_fall & tx_en & (in_xfer || state_q == serial_shift_pkg::ST_CLOCK_WAIT);
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q)
      so_q <= serial_shift_pkg::SO_RESET;
    else if (out_fall)
      so_q <= shift_q[0];
    else if (wr_pmc && !in_xfer)
      so_q <= pwdata[serial_shift_pkg::PMC_IDLE_BIT];
  end

  // Pin drivers, all from flip-flops
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sck_out  <= 1'b1;
      sck_oe_n <= 1'b1;
      so_out   <= serial_shift_pkg::SO_RESET;
    end else begin
      sck_out  <= sck_q;
      sck_oe_n <= ~(pin_en & ~ext_clk);
      so_out   <= so_q;
    end
  end

  // Read data; write-only registers read as zero
  logic [31:0] rd_d;
  always_comb begin
    rd_d = 32'h0000_0000;
    case (idx)
      serial_shift_pkg::IDX_SHIFT_LOW:  rd_d[3:0] = shift_q[3:0];
      serial_shift_pkg::IDX_SHIFT_HIGH: rd_d[3:0] = shift_q[7:4];
      serial_shift_pkg::IDX_STATUS: begin
        rd_d[serial_shift_pkg::STATUS_SCK_BIT]  = sck_oe_n ? sck_lvl_q : sck_q;
        rd_d[serial_shift_pkg::STATUS_SO_BIT]   = so_q;
        rd_d[serial_shift_pkg::STATUS_DONE_BIT] = done_q;
        rd_d[serial_shift_pkg::STATUS_STATE_LSB +: 2] = state_q;
        rd_d[serial_shift_pkg::STATUS_COUNT_LSB +: 3] = count_q;
      end
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      if (setup && !pwrite)
        prdata <= rd_d;
    end
  end

  // idle_q kept for software view symmetry with port_mode_c
  logic unused_ok;
  assign unused_ok = idle_q ^ pma_q[2] ^ access;

endmodule

`default_nettype wire

/* File: verification/serial_shift_assertions.sv */
// Checker for the serial shift interface top module.
// Assumes aligned APB byte addresses.
`timescale 1ns/10ps
`default_nettype none
module serial_shift_assertions (
  input wire logic        clock,    // Clock
  input wire logic        arst_n,   // Reset
  input wire logic        psel,     // Select
  input wire logic        penable,  // Enable
  input wire logic        pwrite,   // Direction
  input wire logic [7:0]  paddr,    // Address
  input wire logic [31:0] pwdata,   // Write data
  input wire logic [31:0] prdata,   // Read data
  input wire logic        pready,   // Ready
  input wire logic        pslverr,  // Error
  input wire logic        sck_in,   // Clock pin
  input wire logic        sck_out,  // Clock drive
  input wire logic        sck_oe_n, // Drive enable
  input wire logic        si_in,    // Data in
  input wire logic        so_out    // Data out
);
  logic [3:0] smr_q;
  logic       rng_q;
  logic [1:0] mode_q;
  logic [2:0] quiet_q;
  logic [3:0] rise_q;
  logic       sck_q;
  logic       wr;
  logic       unmapped;
  assign wr = psel && penable && pready && pwrite;
  assign unmapped = !(paddr inside {8'h10, 8'h14, 8'h18, 8'h1C, 8'h94, 8'hC0, 8'hC4});
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      smr_q <= 4'h0;
      rng_q <= 1'b0;
      mode_q <= 2'h0;
    end else if (wr) begin
      if (paddr == 8'h14) smr_q <= pwdata[3:0];
      if (paddr == 8'h94) rng_q <= pwdata[0];
      if (paddr == 8'h10) mode_q <= pwdata[1:0];
    end
  end
  // Settling window after any write
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) quiet_q <= 3'h0;
    else if (wr) quiet_q <= 3'h0;
    else if (quiet_q != 3'h7) quiet_q <= quiet_q + 3'h1;
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sck_q <= 1'b1;
      rise_q <= 4'h0;
    end else begin
      sck_q <= sck_out;
      if (wr && (paddr == 8'hC0 || paddr == 8'h14)) rise_q <= 4'h0;
      else if (!sck_oe_n && sck_out && !sck_q && rise_q != 4'hF) rise_q <= rise_q + 4'h1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_low_two;
    !sck_out [*2] ##1 sck_out;
  endsequence
  property p_ready; s_setup |=> pready; endproperty
  property p_pulse; pready |=> !pready; endproperty
  property p_err; s_setup |=> pslverr == $past(unmapped); endproperty
  property p_wo;
    s_setup ##0 (!pwrite && paddr inside {8'h10, 8'h14, 8'h94, 8'hC0}) |=> prdata == 32'h0;
  endproperty
  property p_ext;
    quiet_q == 3'h7 && (smr_q[2:1] == serial_shift_pkg::RATE_EXTERNAL_TOP || !smr_q[3])
      |-> sck_oe_n;
  endproperty
  property p_half;
    quiet_q == 3'h7 && smr_q == 4'hD && !rng_q && !sck_oe_n && !psel && $fell(sck_out)
      |-> s_low_two;
  endproperty
  property p_so;
    !sck_oe_n && quiet_q == 3'h7 && rise_q < 4'h7 && $changed(so_out)
      |-> !sck_out && ($past(sck_out) || $past(sck_out, 2));
  endproperty
  property p_eight; mode_q != 2'h0 && !sck_oe_n |-> rise_q <= 4'h8; endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  a_pulse: assert property (p_pulse) else $error("ready held too long");
  a_err: assert property (p_err) else $error("wrong error response");
  a_wo: assert property (p_wo) else $error("write-only read not zero");
  a_ext: assert property (p_ext) else $error("clock pin driven");
  a_half: assert property (p_half) else $error("wrong clock half period");
  a_so: assert property (p_so) else $error("output moved off falling clock");
  a_eight: assert property (p_eight) else $error("more than eight clocks");
endmodule
bind serial_shift_if serial_shift_assertions chk_i (.clock(clock), .arst_n(arst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .sck_in(sck_in), .sck_out(sck_out),
  .sck_oe_n(sck_oe_n), .si_in(si_in), .so_out(so_out));
`default_nettype wire

/* File: verification/serial_peer.sv */
// Far-side serial peer: drives clock bursts, shifts data both ways.
// Assumes a pull-up on the clock pin resolved by the bench.
`timescale 1ns/10ps
`default_nettype none
module serial_peer (
  input  wire logic clock,   // Pacing clock
  input  wire logic sck_pin, // Resolved clock pin
  input  wire logic so_pin,  // Device output
  output logic      sck_drv, // Clock level
  output logic      drv_n,   // Low while driving
  output logic      si_pin   // Device input
);
  logic [7:0] txq;
  logic [7:0] rxb;
  initial begin
    sck_drv = 1'b1;
    drv_n = 1'b1;
    si_pin = 1'b0;
    txq = 8'h00;
    rxb = 8'h00;
  end
  // Refill with inverted bits so stale data never looks valid
  always @(negedge sck_pin) begin
    si_pin <= txq[0];
    txq <= {~txq[0], txq[7:1]};
  end
  always @(posedge sck_pin) rxb <= {so_pin, rxb[7:1]};
  task automatic load(input logic [7:0] b);
    txq = b;
  endtask
  // Clock stands high between bursts
  task automatic burst(input int n);
    repeat (n) begin
      drv_n <= 1'b0;
      sck_drv <= 1'b0;
      repeat (10) @(posedge clock);
      sck_drv <= 1'b1;
      repeat (10) @(posedge clock);
    end
    drv_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

/* File: verification/tb.sv */
// Self-checking bench for the serial shift interface.
// Assumes the peer model and a pulled-up clock pin.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clock, arst_n, psel, penable, pwrite, pready, pslverr;
  logic sck_out, sck_oe_n, so_out, peer_sck, peer_n, si, e;
  logic [7:0] paddr, tx, px;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] lo;
  logic [7:0] wo [4] = '{8'h10, 8'h14, 8'h94, 8'hC0};
  int bad_count, checks, n;
  wire logic sck_pin = !sck_oe_n ? sck_out : (!peer_n ? peer_sck : 1'b1);
  serial_shift_if uut (.clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sck_in(sck_pin), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
    .si_in(si), .so_out(so_out));
  serial_peer peer (.clock(clock), .sck_pin(sck_pin), .so_pin(so_out), .sck_drv(peer_sck),
    .drv_n(peer_n), .si_pin(si));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic final_report();
    if (bad_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 40);
    if (k >= 40) begin
      bad_count++;
      final_report();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic st(input logic [2:0] cnt, input logic [1:0] s, input logic f);
    apb(1'b0, 8'hC4, 32'h0);
    chk({26'h0, r[10:8], r[5:4], r[2]}, {26'h0, cnt, s, f});
  endtask
  task automatic wait_flag();
    n = 0;
    do begin
      apb(1'b0, 8'hC4, 32'h0);
      n++;
    end while (r[2] !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      bad_count++;
      final_report();
    end
  endtask
  task automatic load_data();
    tx = 8'($urandom);
    px = 8'($urandom);
    peer.load(px);
    apb(1'b1, 8'h18, {28'h0, tx[3:0]});
    apb(1'b1, 8'h1C, {28'h0, tx[7:4]});
  endtask
  task automatic chk_rx();
    apb(1'b0, 8'h18, 32'h0);
    lo = r[3:0];
    apb(1'b0, 8'h1C, 32'h0);
    chk({24'h0, r[3:0], lo}, {24'h0, px});
  endtask
  function automatic int ratio(int c, int g);
    return (2048 >> (2 * c)) << g;
  endfunction
  initial begin
    bad_count = 0;
    checks = 0;
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    void'($urandom(32'h0f6be27f));
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    st(3'h0, 2'h0, 1'b0);
    foreach (wo[i]) begin
      apb(1'b0, wo[i], 32'h0);
      chk(r, 32'h0);
    end
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    for (int v = 0; v < 2; v++) begin
      apb(1'b1, 8'h94, 32'(2 * v));
      repeat (2) @(posedge clock);
      chk({31'h0, so_out}, 32'(v));
      apb(1'b0, 8'hC4, 32'h0);
      chk({31'h0, r[1]}, 32'(v));
      chk({31'h0, r[0]}, 32'h1);
    end
    for (int m = 1; m < 4; m++) begin
      apb(1'b1, 8'h10, 32'(m));
      apb(1'b1, 8'h14, 32'hC);
      load_data();
      apb(1'b1, 8'hC0, 32'h1);
      wait_flag();
      st(3'h0, 2'h0, 1'b1);
      if (m != 2) chk({24'h0, peer.rxb}, {24'h0, tx});
      if (m != 1) chk_rx();
      apb(1'b1, 8'hC4, 32'h4);
    end
    apb(1'b1, 8'h10, 32'h0);
    for (int g = 0; g < 2; g++) begin
      for (int c = 0; c < 6; c++) begin
        apb(1'b1, 8'h94, {30'h0, 1'b1, g[0]});
        apb(1'b1, 8'h14, 32'(8 + c));
        apb(1'b1, 8'hC0, 32'h1);
        n = 0;
        while (sck_out !== 1'b0 && n < 20000) begin
          @(posedge clock);
          n++;
        end
        n = 0;
        while (sck_out === 1'b0 && n < 20000) begin
          @(posedge clock);
          n++;
        end
        chk(32'(n), 32'(ratio(c, g)));
        if (c == 5) st(3'h0, 2'h3, 1'b0);
        apb(1'b1, 8'h14, 32'h0);
      end
    end
    st(3'h0, 2'h0, 1'b0);
    apb(1'b1, 8'h10, 32'h3);
    apb(1'b1, 8'h14, 32'hE);
    load_data();
    apb(1'b1, 8'hC0, 32'h1);
    st(3'h0, 2'h1, 1'b0);
    peer.burst(8);
    st(3'h0, 2'h1, 1'b1);
    chk({24'h0, peer.rxb}, {24'h0, tx});
    chk_rx();
    peer.burst(1);
    st(3'h1, 2'h2, 1'b1);
    apb(1'b1, 8'hC4, 32'h4);
    apb(1'b1, 8'h14, 32'hE);
    st(3'h0, 2'h0, 1'b1);
    apb(1'b1, 8'hC4, 32'h4);
    apb(1'b1, 8'hC0, 32'h1);
    peer.burst(3);
    st(3'h3, 2'h2, 1'b0);
    apb(1'b1, 8'hC0, 32'h1);
    st(3'h0, 2'h1, 1'b1);
    apb(1'b1, 8'hC4, 32'h4);
    apb(1'b1, 8'h14, 32'hE);
    st(3'h0, 2'h0, 1'b0);
    apb(1'b1, 8'h14, 32'h8);
    apb(1'b1, 8'hC0, 32'h1);
    n = 0;
    while (sck_out !== 1'b0 && n < 20000) begin
      @(posedge clock);
      n++;
    end
    st(3'h0, 2'h2, 1'b0);
    apb(1'b1, 8'hC0, 32'h1);
    st(3'h0, 2'h1, 1'b0);
    apb(1'b1, 8'h14, 32'h0);
    st(3'h0, 2'h0, 1'b0);
    final_report();
  end
endmodule
`default_nettype wire
